// File: verilog/qpd_pkg.sv
package qpd_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] QPD_ADDR_CTRL = 8'h00;
   localparam logic [7:0] QPD_ADDR_FILT = 8'h04;
   localparam logic [7:0] QPD_ADDR_POS = 8'h08;
   localparam logic [7:0] QPD_ADDR_MAX = 8'h0C;
   localparam logic [15:0] QPD_RST_16 = 16'h0000;
   localparam logic [15:0] QPD_RST_MAX = 16'hFFFF;
   localparam logic [1:0] QPD_RESP_OK = 2'h0;
   localparam logic [1:0] QPD_RESP_ERR = 2'h2;
   // ==========================================================
   // field positions
   localparam int QPD_B_ERR = 15;
   localparam int QPD_B_IDL = 13;
   localparam int QPD_B_DIR = 11;
   localparam int QPD_B_MODE = 8;
   localparam int QPD_B_SWAP = 7;
   localparam int QPD_B_DOUT = 6;
   localparam int QPD_B_GATE = 5;
   localparam int QPD_B_PS = 3;
   localparam int QPD_B_MARKER_RESET_ENABLE = 2;
   localparam int QPD_B_TIMER_CLOCK_SOURCE_SELECT = 1;
   localparam int QPD_B_SRC = 0;
   localparam int QPD_B_IMV = 9;
   localparam int QPD_B_COUNT_ERROR_IRQ_DISABLE = 8;
   localparam int QPD_B_FILTER_OUTPUT_ENABLE = 7;
   localparam int QPD_B_QECK = 4;
   // ==========================================================
   // mode codes
   localparam logic [2:0] QPD_M_OFF = 3'h0;
   localparam logic [2:0] QPD_M_TMR = 3'h1;
   localparam logic [2:0] QPD_M_X2IDX = 3'h4;
   localparam logic [2:0] QPD_M_X2MAX = 3'h5;
   localparam logic [2:0] QPD_M_X4IDX = 3'h6;
   localparam logic [2:0] QPD_M_X4MAX = 3'h7;

   // terminal count of the timer prescaler
   function automatic logic [7:0] qpd_ps_term(input logic [1:0] s);
      case (s)
         2'h3: qpd_ps_term = 8'hFF;
         2'h2: qpd_ps_term = 8'h3F;
         2'h1: qpd_ps_term = 8'h07;
         default: qpd_ps_term = 8'h00;
      endcase
   endfunction

   // terminal count of the filter clock divider
   function automatic logic [7:0] qpd_fd_term(input logic [2:0] s);
      case (s)
         3'h7: qpd_fd_term = 8'hFF;
         3'h6: qpd_fd_term = 8'h7F;
         3'h5: qpd_fd_term = 8'h3F;
         3'h4: qpd_fd_term = 8'h1F;
         3'h3: qpd_fd_term = 8'h0F;
         3'h2: qpd_fd_term = 8'h03;
         3'h1: qpd_fd_term = 8'h01;
         default: qpd_fd_term = 8'h00;
      endcase
   endfunction
endpackage

// File: verilog/qpd_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module qpd_top import qpd_pkg::*; (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic idle_i,
   input wire logic phase_a_input_i,
   input wire logic phase_b_input_i,
   input wire logic marker_input_i,
   output logic dir_o,
   output logic dir_oe_o,
   output logic count_error_irq_o,
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i
);
   typedef struct packed {
      logic [2:0] mode;
      logic err;
      logic idl;
      logic dir;
      logic swap;
      logic dout;
      logic gate;
      logic [1:0] ps;
      logic marker_reset_enable;
      logic timer_clock_source_select;
      logic src;
      logic [1:0] imv;
      logic count_error_irq_disable;
      logic filter_output_enable;
      logic [2:0] qeck;
      logic [15:0] pos;
      logic [15:0] max;
      logic [7:0] fdiv;
      logic [7:0] psc;
      logic [2:0] h0;
      logic [2:0] h1;
      logic [2:0] filt;
      logic pa;
      logic pb;
      logic irq;
      logic awr;
      logic wr;
      logic [7:0] waddr;
      logic [15:0] wdat;
      logic [1:0] wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic arr;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } qpd_state_t;

   qpd_state_t s_r;
   qpd_state_t s_nxt;

   // ==========================================================
   // byte-lane merge, used by every writable register
   function automatic logic [15:0] qpd_merge(input logic [15:0] old,
      input logic [15:0] d, input logic [1:0] stb);
      qpd_merge = {stb[1] ? d[15:8] : old[15:8],
                   stb[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic qpd_mapped(input logic [7:0] a);
      qpd_mapped = (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
   endfunction

   logic [2:0] raw;
   logic [2:0] inp;
   logic a;
   logic b;
   logic idx;
   logic ftick;
   logic run;
   logic enc;
   logic x4;
   logic step;
   logic up;
   logic idx_hit;
   logic tev;
   logic set_err;
   logic [15:0] ctrl_rd;
   logic [15:0] filt_rd;
   logic [15:0] wv;

   always_comb begin
      s_nxt = s_r;
      raw = {marker_input_i, phase_b_input_i, phase_a_input_i};
      step = 1'b0;
      up = s_r.dir;
      idx_hit = 1'b0;
      tev = 1'b0;
      set_err = 1'b0;
      wv = 16'h0000;
      // ======================================================
      // noise filters
      // >= so a smaller divide written mid-count does not wait for a wrap
      ftick = (s_r.fdiv >= qpd_fd_term(s_r.qeck));
      s_nxt.fdiv = ftick ? 8'h00 : s_r.fdiv + 8'h01;
      if (ftick) begin
         s_nxt.h0 = raw;
         s_nxt.h1 = s_r.h0;
         for (int i = 0; i < 3; i++) begin
            // level must match on three filter samples in a row
            if (raw[i] == s_r.h0[i] && raw[i] == s_r.h1[i]) begin
               s_nxt.filt[i] = raw[i];
            end
         end
      end
      inp = s_r.filter_output_enable ? s_r.filt : raw;
      a = s_r.swap ? inp[1] : inp[0];
      b = s_r.swap ? inp[0] : inp[1];
      idx = inp[2];
      s_nxt.pa = a;
      s_nxt.pb = b;
      // ======================================================
      // position counter
      run = !(s_r.idl && idle_i);
      enc = s_r.mode[2];
      x4 = s_r.mode[1];
      if (enc) begin
         // x2 listens to A only; x4 does not count a double edge
         step = x4 ? ((a != s_r.pa) ^ (b != s_r.pb))
                   : (a != s_r.pa);
         up = a ^ s_r.pb;
         if (x4) begin
            idx_hit = (b == s_r.imv[1]) && (a == s_r.imv[0]);
         end else begin
            idx_hit = (s_r.imv[1] ? b : a) == s_r.imv[0];
         end
         idx_hit = idx_hit && idx && s_r.marker_reset_enable && !s_r.mode[0];
      end else if (s_r.mode == QPD_M_TMR) begin
         up = s_r.src ? b : s_r.dir;
         tev = s_r.timer_clock_source_select ? (a && !s_r.pa) : 1'b1;
         tev = tev && (!s_r.gate || a);
         if (tev && run) begin
            if (s_r.psc >= qpd_ps_term(s_r.ps)) begin
               s_nxt.psc = 8'h00;
               step = 1'b1;
            end else begin
               s_nxt.psc = s_r.psc + 8'h01;
            end
         end
      end
      if (enc && step && run) begin
         s_nxt.dir = up;
      end
      if (run && (enc || s_r.mode == QPD_M_TMR)) begin
         if (idx_hit) begin
            s_nxt.pos = QPD_RST_16;
         end else if (step && up) begin
            if (s_r.pos == s_r.max) begin
               s_nxt.pos = QPD_RST_16;
               set_err = enc && !s_r.mode[0];
            end else begin
               s_nxt.pos = s_r.pos + 16'h0001;
            end
         end else if (step) begin
            if (s_r.pos == QPD_RST_16) begin
               s_nxt.pos = s_r.max;
               set_err = enc && !s_r.mode[0];
            end else begin
               s_nxt.pos = s_r.pos - 16'h0001;
            end
         end
      end
      s_nxt.irq = set_err && !s_r.count_error_irq_disable;
      // ======================================================
      // register read views
      ctrl_rd = {s_r.err, 1'b0, s_r.idl, idx, s_r.dir, s_r.mode,
                 s_r.swap, s_r.dout, s_r.gate, s_r.ps, s_r.marker_reset_enable,
                 s_r.timer_clock_source_select, s_r.src};
      filt_rd = {5'h00, s_r.imv, s_r.count_error_irq_disable, s_r.filter_output_enable, s_r.qeck, 4'h0};
      // ======================================================
      // axi4-lite write channel
      if (awvalid_i && s_r.awr) begin
         s_nxt.awr = 1'b0;
         s_nxt.waddr = awaddr_i;
      end
      if (wvalid_i && s_r.wr) begin
         s_nxt.wr = 1'b0;
         s_nxt.wdat = wdata_i[15:0];
         s_nxt.wstb = wstrb_i[1:0];
      end
      if (!s_r.awr && !s_r.wr && !s_r.bvalid) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = qpd_mapped(s_r.waddr) ? QPD_RESP_OK : QPD_RESP_ERR;
         case (s_r.waddr)
            QPD_ADDR_CTRL: begin
               wv = qpd_merge(ctrl_rd, s_r.wdat, s_r.wstb);
               s_nxt.idl = wv[QPD_B_IDL];
               s_nxt.mode = wv[QPD_B_MODE +: 3];
               s_nxt.swap = wv[QPD_B_SWAP];
               s_nxt.dout = wv[QPD_B_DOUT];
               s_nxt.gate = wv[QPD_B_GATE];
               s_nxt.ps = wv[QPD_B_PS +: 2];
               s_nxt.marker_reset_enable = wv[QPD_B_MARKER_RESET_ENABLE];
               s_nxt.timer_clock_source_select = wv[QPD_B_TIMER_CLOCK_SOURCE_SELECT];
               s_nxt.src = wv[QPD_B_SRC];
               if (!enc) begin
                  s_nxt.dir = wv[QPD_B_DIR];
               end
               // writing 0 clears; a new error in this cycle still sets
               s_nxt.err = wv[QPD_B_ERR] & s_r.err;
            end
            QPD_ADDR_FILT: begin
               wv = qpd_merge(filt_rd, s_r.wdat, s_r.wstb);
               s_nxt.imv = wv[QPD_B_IMV +: 2];
               s_nxt.count_error_irq_disable = wv[QPD_B_COUNT_ERROR_IRQ_DISABLE];
               s_nxt.filter_output_enable = wv[QPD_B_FILTER_OUTPUT_ENABLE];
               s_nxt.qeck = wv[QPD_B_QECK +: 3];
            end
            QPD_ADDR_POS: begin
               // software write wins over a count in the same cycle
               s_nxt.pos = qpd_merge(s_r.pos, s_r.wdat, s_r.wstb);
            end
            QPD_ADDR_MAX: begin
               s_nxt.max = qpd_merge(s_r.max, s_r.wdat, s_r.wstb);
            end
            default: begin
            end
         endcase
      end
      if (set_err) begin
         s_nxt.err = 1'b1;
      end
      if (s_r.bvalid && bready_i) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awr = 1'b1;
         s_nxt.wr = 1'b1;
      end
      // ======================================================
      // axi4-lite read channel
      if (arvalid_i && s_r.arr) begin
         s_nxt.arr = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = qpd_mapped(araddr_i) ? QPD_RESP_OK : QPD_RESP_ERR;
         case (araddr_i)
            QPD_ADDR_CTRL: s_nxt.rdata = {16'h0000, ctrl_rd};
            QPD_ADDR_FILT: s_nxt.rdata = {16'h0000, filt_rd};
            // whole word in one beat, so no torn value
            QPD_ADDR_POS: s_nxt.rdata = {16'h0000, s_r.pos};
            QPD_ADDR_MAX: s_nxt.rdata = {16'h0000, s_r.max};
            default: s_nxt.rdata = 32'h00000000;
         endcase
      end
      if (s_r.rvalid && rready_i) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arr = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
         s_r.max <= QPD_RST_MAX;
         s_r.awr <= 1'b1;
         s_r.wr <= 1'b1;
         s_r.arr <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs, all straight from the state register
   assign dir_o = s_r.dir;
   assign dir_oe_o = s_r.dout;
   assign count_error_irq_o = s_r.irq;
   assign awready_o = s_r.awr;
   assign wready_o = s_r.wr;
   assign bvalid_o = s_r.bvalid;
   assign bresp_o = s_r.bresp;
   assign arready_o = s_r.arr;
   assign rvalid_o = s_r.rvalid;
   assign rresp_o = s_r.rresp;
   assign rdata_o = s_r.rdata;
endmodule // qpd_top

// File: verification/qpd_top_asserts.sv
`timescale 1ns/1ps
module qpd_top_asserts import qpd_pkg::*; (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic awvalid_i,
   input wire logic awready_o,
   input wire logic wvalid_i,
   input wire logic wready_o,
   input wire logic bvalid_o,
   input wire logic bready_i,
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   input wire logic arready_o,
   input wire logic [31:0] rdata_o,
   input wire logic [1:0] rresp_o,
   input wire logic rvalid_o,
   input wire logic rready_i,
   input wire logic count_error_irq_o
);
   // ==========================================
   // bus timing and event pulse
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_read_answer: assert property (
      arvalid_i && arready_o |=> rvalid_o && !arready_o) else $error("rd late");
   a_write_answer: assert property (
      awvalid_i && awready_o && wvalid_i && wready_o
      |=> !wready_o ##1 bvalid_o) else $error("wr late");
   a_read_release: assert property (
      rvalid_o && rready_i |=> !rvalid_o && arready_o) else $error("rd held");
   a_write_release: assert property (
      bvalid_o && bready_i |=> !bvalid_o) else $error("wr held");
   a_read_error: assert property (
      arvalid_i && arready_o && araddr_i[7:4] != 4'h0
      |=> rresp_o == QPD_RESP_ERR) else $error("no slverr");
   a_read_okay: assert property (
      arvalid_i && arready_o && araddr_i == QPD_ADDR_POS
      |=> rresp_o == QPD_RESP_OK) else $error("bad okay");
   a_upper_zero: assert property (
      rvalid_o && rresp_o == QPD_RESP_OK |-> rdata_o[31:16] == 16'h0000)
      else $error("upper half set");
   a_irq_pulse: assert property (
      $rose(count_error_irq_o) |=> !count_error_irq_o) else $error("irq long");
endmodule // qpd_top_asserts

bind qpd_top qpd_top_asserts qpd_top_asserts_inst (
   .clk_i(clk_i),
   .rstn_i(rstn_i),
   .awvalid_i(awvalid_i),
   .awready_o(awready_o),
   .wvalid_i(wvalid_i),
   .wready_o(wready_o),
   .bvalid_o(bvalid_o),
   .bready_i(bready_i),
   .araddr_i(araddr_i),
   .arvalid_i(arvalid_i),
   .arready_o(arready_o),
   .rdata_o(rdata_o),
   .rresp_o(rresp_o),
   .rvalid_o(rvalid_o),
   .rready_i(rready_i),
   .count_error_irq_o(count_error_irq_o)
);

// File: verification/qpd_enc.sv
`timescale 1ns/1ps
module qpd_enc (
   input wire logic clk_i,
   output logic phase_a_o,
   output logic phase_b_o,
   output logic marker_o
);
   // ==========================================
   // encoder disc
   // ph walks 00,10,11,01 on (a,b) turning forward, so a leads b
   logic [1:0] ph = 2'h0;
   initial marker_o = 1'b0;
   assign phase_a_o = ph[1] ^ ph[0];
   assign phase_b_o = ph[1];

   // one edge per step: both phases never move together
   task automatic step(input logic fwd);
      @(posedge clk_i);
      ph <= fwd ? ph + 2'h1 : ph - 2'h1;
      repeat (3) @(posedge clk_i);
   endtask

   task automatic mark(input logic v);
      @(posedge clk_i);
      marker_o <= v;
      repeat (3) @(posedge clk_i);
   endtask
endmodule // qpd_enc

// File: verification/qpd_top_tb.sv
`timescale 1ns/1ps
module qpd_top_tb import qpd_pkg::*; ;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic idle_i = 1'b0;
   logic phase_a_input_i, phase_b_input_i, marker_input_i;
   logic dir_o, dir_oe_o, count_error_irq_o;
   logic [7:0] awaddr_i = 8'h00;
   logic [7:0] araddr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic [3:0] wstrb_i = 4'hF;
   logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
   logic arvalid_i = 1'b0, rready_i = 1'b0;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic [1:0] bresp_o, rresp_o;
   logic [31:0] rdata_o;
   int failures = 0, tests_run = 0, irqs = 0;

   qpd_top qpd_top_inst (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .idle_i(idle_i),
      .phase_a_input_i(phase_a_input_i),
      .phase_b_input_i(phase_b_input_i),
      .marker_input_i(marker_input_i),
      .dir_o(dir_o),
      .dir_oe_o(dir_oe_o),
      .count_error_irq_o(count_error_irq_o),
      .awaddr_i(awaddr_i),
      .awvalid_i(awvalid_i),
      .awready_o(awready_o),
      .wdata_i(wdata_i),
      .wstrb_i(wstrb_i),
      .wvalid_i(wvalid_i),
      .wready_o(wready_o),
      .bresp_o(bresp_o),
      .bvalid_o(bvalid_o),
      .bready_i(bready_i),
      .araddr_i(araddr_i),
      .arvalid_i(arvalid_i),
      .arready_o(arready_o),
      .rdata_o(rdata_o),
      .rresp_o(rresp_o),
      .rvalid_o(rvalid_o),
      .rready_i(rready_i)
   );
   qpd_enc qpd_enc_inst (.clk_i(clk_i), .phase_a_o(phase_a_input_i),
      .phase_b_o(phase_b_input_i), .marker_o(marker_input_i));

   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (count_error_irq_o === 1'b1) irqs++;

   // ==========================================
   // checking and bus tasks
   task automatic stop_test;
      $display("compared %0d mismatched %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] g, e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic tmo(input int n);
      if (n > 60) begin
         failures++;
         stop_test();
      end
   endtask

   function automatic logic [1:0] rsp(input logic [7:0] a);
      return (a[7:4] != 4'h0 || a[1:0] != 2'h0) ? QPD_RESP_ERR : QPD_RESP_OK;
   endfunction

   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      awaddr_i <= ad;
      wdata_i <= {16'h0000, d};
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         tmo(++n);
         if (awready_o) awvalid_i <= 1'b0;
         if (wready_o) wvalid_i <= 1'b0;
      end while (bvalid_o !== 1'b1);
      bready_i <= 1'b0;
      chk("bresp", 32'(bresp_o), 32'(rsp(ad)));
   endtask

   task automatic rd(input logic [7:0] ad, input logic [15:0] e);
      int n;
      n = 0;
      @(posedge clk_i);
      araddr_i <= ad;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         tmo(++n);
         if (arready_o) arvalid_i <= 1'b0;
      end while (rvalid_o !== 1'b1);
      rready_i <= 1'b0;
      chk("rresp", 32'(rresp_o), 32'(rsp(ad)));
      if (rsp(ad) == QPD_RESP_OK) chk("rdata", rdata_o, 32'(e));
   endtask

   // ==========================================
   // scenarios
   task automatic scen_regs;
      rd(QPD_ADDR_CTRL, QPD_RST_16);
      rd(QPD_ADDR_MAX, QPD_RST_MAX);
      rd(8'h12, QPD_RST_16);
      wr(8'h40, 16'h0001);
      // counting is off, so byte lanes cannot tear
      wr(QPD_ADDR_POS, 16'h0005);
      wstrb_i <= 4'h2;
      wr(QPD_ADDR_POS, 16'hAB00);
      wstrb_i <= 4'hF;
      rd(QPD_ADDR_POS, 16'hAB05);
   endtask

   task automatic scen_count;
      // control, start, steps, forward, expected, maximum
      logic [15:0] t [5][6] = '{
         '{16'h0740, 16'h0000, 16'h0004, 16'h0001, 16'h0004, 16'hFFFF},
         '{16'h0740, 16'h0004, 16'h0002, 16'h0000, 16'h0002, 16'hFFFF},
         '{16'h0500, 16'h0000, 16'h0004, 16'h0001, 16'h0002, 16'hFFFF},
         '{16'h0780, 16'h000A, 16'h0002, 16'h0001, 16'h0008, 16'hFFFF},
         '{16'h0700, 16'h0000, 16'h0008, 16'h0001, 16'h0000, 16'h0003}};
      for (int i = 0; i < 5; i++) begin
         wr(QPD_ADDR_MAX, t[i][5]);
         wr(QPD_ADDR_CTRL, t[i][0]);
         wr(QPD_ADDR_POS, t[i][1]);
         repeat (t[i][2]) qpd_enc_inst.step(t[i][3][0]);
         rd(QPD_ADDR_POS, t[i][4]);
         chk("dir", 32'(dir_o), 32'(t[i][3][0] ^ t[i][0][7]));
         chk("dir_oe", 32'(dir_oe_o), 32'(t[i][0][6]));
      end
   endtask

   task automatic scen_index;
      // control, filter, expected count with the marker high
      logic [15:0] t [5][3] = '{'{16'h0604, 16'h0000, 16'h0000},
         '{16'h0600, 16'h0000, 16'h0005}, '{16'h0604, 16'h0200, 16'h0005},
         '{16'h0404, 16'h0400, 16'h0000}, '{16'h0404, 16'h0600, 16'h0005}};
      for (int i = 0; i < 5; i++) begin
         wr(QPD_ADDR_FILT, t[i][1]);
         wr(QPD_ADDR_CTRL, t[i][0]);
         wr(QPD_ADDR_POS, 16'h0005);
         qpd_enc_inst.mark(1'b1);
         rd(QPD_ADDR_CTRL, t[i][0] | 16'h1800);
         rd(QPD_ADDR_POS, t[i][2]);
         qpd_enc_inst.mark(1'b0);
      end
   endtask

   task automatic scen_err;
      wr(QPD_ADDR_FILT, 16'h0000);
      wr(QPD_ADDR_CTRL, 16'h0600);
      wr(QPD_ADDR_POS, 16'h0000);
      qpd_enc_inst.step(1'b0);
      rd(QPD_ADDR_POS, 16'h0003);
      rd(QPD_ADDR_CTRL, 16'h8600);
      chk("irq", irqs, 32'h1);
      wr(QPD_ADDR_FILT, 16'h0100);
      wr(QPD_ADDR_POS, 16'h0000);
      qpd_enc_inst.step(1'b0);
      chk("irq", irqs, 32'h1);
      wr(QPD_ADDR_CTRL, 16'h0600);
      rd(QPD_ADDR_CTRL, 16'h0600);
   endtask

   task automatic scen_timer;
      logic [15:0] e [4] = '{16'h0100, 16'h0020, 16'h0004, 16'h0001};
      idle_i <= 1'b1;
      wr(QPD_ADDR_MAX, QPD_RST_MAX);
      wr(QPD_ADDR_CTRL, 16'h2000);
      for (int s = 0; s < 4; s++) begin
         wr(QPD_ADDR_POS, 16'h0000);
         wr(QPD_ADDR_CTRL, 16'h2900 | 16'(s << QPD_B_PS));
         @(posedge clk_i);
         idle_i <= 1'b0;
         repeat (256) @(posedge clk_i);
         idle_i <= 1'b1;
         rd(QPD_ADDR_POS, e[s]);
      end
      chk("dir", 32'(dir_o), 32'h1);
   endtask

   task automatic scen_tsrc;
      // idle stays requested: with the halt bit clear the timer keeps going
      wr(QPD_ADDR_CTRL, 16'h0903);
      wr(QPD_ADDR_POS, 16'h0010);
      // one rising edge of A, with B low, in four steps
      repeat (4) qpd_enc_inst.step(1'b1);
      rd(QPD_ADDR_POS, 16'h000F);
      qpd_enc_inst.step(1'b1);
      wr(QPD_ADDR_CTRL, 16'h0920);
      wr(QPD_ADDR_POS, 16'h0000);
      repeat (20) @(posedge clk_i);
      rd(QPD_ADDR_POS, 16'h0000);
      // A high for the step's three edges and the read's first edge
      qpd_enc_inst.step(1'b0);
      rd(QPD_ADDR_POS, 16'h0004);
      wr(QPD_ADDR_CTRL, 16'h0300);
      wr(QPD_ADDR_POS, 16'h0007);
      repeat (4) qpd_enc_inst.step(1'b1);
      rd(QPD_ADDR_POS, 16'h0007);
   endtask

   task automatic scen_filt;
      wr(QPD_ADDR_FILT, 16'h00F0);
      wr(QPD_ADDR_CTRL, 16'h0000);
      qpd_enc_inst.mark(1'b1);
      rd(QPD_ADDR_CTRL, 16'h0000);
      // three ticks of a 1:256 filter clock fit in 800 cycles
      repeat (800) @(posedge clk_i);
      rd(QPD_ADDR_CTRL, 16'h1000);
      wr(QPD_ADDR_FILT, 16'h0080);
      qpd_enc_inst.mark(1'b0);
      rd(QPD_ADDR_CTRL, 16'h0000);
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      scen_regs();
      scen_count();
      scen_index();
      scen_err();
      scen_timer();
      scen_tsrc();
      scen_filt();
      stop_test();
   end
endmodule // qpd_top_tb
